// file: hdl/ifos_pkg.sv
// constants and types for the input filter and output source block
package ifos_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / US_PER_S;
  localparam logic [7:0] MAX_US_CODE = 8'h64;
  localparam int unsigned OSC_HZ = 100_000;
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int unsigned CNT_W = 15;
  localparam int unsigned OSC_W = 12;

  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SMB = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_GF_LO = 8'h10;
  localparam logic [7:0] ADDR_GF_HI = 8'h14;
  localparam logic [7:0] ADDR_PW = 8'h18;
  localparam logic [7:0] ADDR_HY_LO = 8'h1C;
  localparam logic [7:0] ADDR_HY_HI = 8'h20;
  localparam logic [7:0] ADDR_RANGE = 8'h24;
  localparam logic [7:0] ADDR_PDO_LO = 8'h28;
  localparam logic [7:0] ADDR_PDO_HI = 8'h2C;
  localparam int unsigned NUM_WORDS = 12;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ***********************************************************
  // field positions and masks
  // ***********************************************************
  localparam int unsigned CTRL_LOGIC_LSB = 0;
  localparam int unsigned CTRL_EDGE_LSB = 4;
  localparam int unsigned CTRL_PD_LSB = 8;
  localparam int unsigned PDO_SRC_LSB = 0;
  localparam int unsigned PDO_MODE_LSB = 2;
  localparam int unsigned STAT_FAULT_LSB = 0;
  localparam int unsigned STAT_WARN_LSB = 8;
  localparam int unsigned STAT_LOGIC_LSB = 12;
  localparam int unsigned STAT_SUP_BIT = 16;
  localparam logic [31:0] MASK_CTRL = 32'h0000_0FFF;
  localparam logic [31:0] MASK_SMB = 32'h0000_00FF;
  localparam logic [31:0] MASK_US = 32'h7F7F_7F7F;
  localparam logic [31:0] MASK_HY = 32'h1F1F_1F1F;
  localparam logic [31:0] MASK_RANGE = 32'h0000_FFFF;
  localparam logic [31:0] MASK_PDO = 32'h1F1F_1F1F;
  localparam int unsigned CP_OUTPUTS = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***********************************************************
  // modes
  // ***********************************************************
  typedef enum logic [1:0] {
    SRC_ENGINE, SRC_SMBUS, SRC_CLOCK, SRC_UNUSED
  } src_t;

  typedef enum logic [2:0] {
    DRV_WEAK_PD, DRV_OPEN_DRAIN, DRV_WEAK_PU_VDD, DRV_STRONG_PU_VDD,
    DRV_WEAK_PU_VP, DRV_STRONG_PU_VP, DRV_STRONG_PD, DRV_CHARGE_PUMP
  } drv_t;

endpackage

// file: hdl/input_filter_output_source.sv
// input conditioning and driver output source selection
module input_filter_output_source
  import ifos_pkg::*;
#(
  parameter int unsigned US_CYC = CLK_PER_US
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // axi4-lite write
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  output logic [1:0] AXI_BRESP_OUT,
  // axi4-lite read
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  input wire logic [7:0] AXI_ARADDR_IN,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  // detector and pin inputs (asynchronous)
  input wire logic [7:0] COMP_IN,
  input wire logic [3:0] WARN_COMP_IN,
  input wire logic [3:0] DFI_PIN_IN,
  input wire logic SUPPLY_OK_IN,
  // sequencing engine
  output logic [7:0] SE_FAULT_OUT,
  output logic [3:0] SE_LOGIC_OUT,
  output logic SE_WARN_OUT,
  input wire logic [7:0] SE_DATA_IN,
  // analog controls
  output logic [39:0] HYST_OUT,
  output logic [15:0] RANGE_OUT,
  output logic [7:0] SEC_RANGE_OUT,
  output logic [3:0] PULLDN_EN_OUT,
  // driver outputs
  output logic [7:0] PDO_DATA_OUT,
  output logic [23:0] PDO_MODE_OUT
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [CNT_W-1:0] us_to_cyc(input logic [7:0] code);
    logic [7:0] c;
    logic [31:0] p;
    c = (code > MAX_US_CODE) ? MAX_US_CODE : code;
    p = 32'(c) * 32'(US_CYC);
    return p[CNT_W-1:0];
  endfunction

  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      ADDR_CTRL: wmask = MASK_CTRL;
      ADDR_SMB: wmask = MASK_SMB;
      ADDR_GF_LO, ADDR_GF_HI, ADDR_PW: wmask = MASK_US;
      ADDR_HY_LO, ADDR_HY_HI: wmask = MASK_HY;
      ADDR_RANGE: wmask = MASK_RANGE;
      ADDR_PDO_LO, ADDR_PDO_HI: wmask = MASK_PDO;
      default: wmask = 32'h0000_0000;
    endcase
  endfunction

  logic [31:0] regs_ff [NUM_WORDS];
  logic [1:0] comp_m_ff [8];
  logic [7:0] comp_s;
  logic [3:0] warn_m_ff, warn_s_ff, dfi_m_ff, dfi_s_ff;
  logic sup_m_ff, sup_s_ff;
  logic [7:0] filt_ff, in_sel, ev;
  logic [CNT_W-1:0] cnt_ff [8];
  logic [CNT_W-1:0] tout [8];
  logic [CNT_W-1:0] pw_cnt_ff [4];
  logic [3:0] logic_mode, edge_mode, warn;
  logic [31:0] ctrl, smb, status;
  logic [OSC_W-1:0] osc_cnt_ff;
  logic osc_ff;
  logic [7:0] pdo_data_ff;
  logic [23:0] pdo_mode_ff;
  logic [39:0] hyst_ff;

  assign ctrl = regs_ff[ADDR_CTRL[5:2]];
  assign smb = regs_ff[ADDR_SMB[5:2]];
  assign logic_mode = ctrl[CTRL_LOGIC_LSB +: 4];
  assign edge_mode = ctrl[CTRL_EDGE_LSB +: 4];

  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      warn_m_ff <= 4'h0;
      warn_s_ff <= 4'h0;
      dfi_m_ff <= 4'h0;
      dfi_s_ff <= 4'h0;
      sup_m_ff <= 1'h0;
      sup_s_ff <= 1'h0;
    end else begin
      warn_m_ff <= WARN_COMP_IN;
      warn_s_ff <= warn_m_ff;
      dfi_m_ff <= DFI_PIN_IN;
      dfi_s_ff <= dfi_m_ff;
      sup_m_ff <= SUPPLY_OK_IN;
      sup_s_ff <= sup_m_ff;
    end
  end

  // ***********************************************************
  // glitch filters and hysteresis
  // ***********************************************************
  for (genvar i = 0; i < 8; i++) begin : g_ch
    logic [31:0] gfw;
    logic [31:0] hyw;
    assign gfw = (i < 4) ? regs_ff[ADDR_GF_LO[5:2]] :
                           regs_ff[ADDR_GF_HI[5:2]];
    assign hyw = (i < 4) ? regs_ff[ADDR_HY_LO[5:2]] :
                           regs_ff[ADDR_HY_HI[5:2]];
    assign tout[i] = us_to_cyc(gfw[8*(i%4) +: 8]);
    assign comp_s[i] = comp_m_ff[i][1];

    // dual input picks logic pin or detector
    if (i < 4) begin : g_pri
      assign in_sel[i] = comp_s[i];
    end else begin : g_dfi
      assign in_sel[i] = logic_mode[i-4] ? dfi_s_ff[i-4] : comp_s[i];
    end

    assign ev[i] = (in_sel[i] != filt_ff[i]) && (cnt_ff[i] >= tout[i]);

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        comp_m_ff[i] <= 2'h0;
        filt_ff[i] <= 1'h0;
        cnt_ff[i] <= '0;
        hyst_ff[5*i +: 5] <= 5'h00;
      end else begin
        comp_m_ff[i] <= {comp_m_ff[i][0], COMP_IN[i]};
        // a return to the old level restarts the count
        if (in_sel[i] == filt_ff[i]) begin
          cnt_ff[i] <= '0;
        end else if (ev[i]) begin
          // output follows once the count hits the timeout
          filt_ff[i] <= in_sel[i];
          cnt_ff[i] <= '0;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 1'b1;
        end
        // hysteresis code only while comparator is faulted
        hyst_ff[5*i +: 5] <= comp_s[i] ? hyw[8*(i%4) +: 5] : 5'h00;
      end
    end
  end

  // ***********************************************************
  // logic inputs: level or edge pulse
  // ***********************************************************
  for (genvar k = 0; k < 4; k++) begin : g_lg
    logic [CNT_W-1:0] pw;
    assign pw = us_to_cyc(regs_ff[ADDR_PW[5:2]][8*k +: 8]);

    // pulse of programmed width, at least one cycle
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        pw_cnt_ff[k] <= '0;
      end else if (ev[k+4] && logic_mode[k] && edge_mode[k]) begin
        pw_cnt_ff[k] <= (pw == '0) ? CNT_W'(1) : pw;
      end else if (pw_cnt_ff[k] != '0) begin
        pw_cnt_ff[k] <= pw_cnt_ff[k] - 1'b1;
      end
    end

    // level mode passes the filtered level
    assign SE_LOGIC_OUT[k] = !logic_mode[k] ? 1'b0 :
                             edge_mode[k] ? (pw_cnt_ff[k] != '0) :
                             filt_ff[k+4];
    // secondary detector live only when input is logic
    assign warn[k] = logic_mode[k] & warn_s_ff[k];
  end

  // logic inputs and detectors share the filter path
  assign SE_FAULT_OUT = {filt_ff[7:4] & ~logic_mode, filt_ff[3:0]};
  // all warnings ORed toward the engine
  assign SE_WARN_OUT = |warn;
  // pull-down only offered in logic mode
  assign PULLDN_EN_OUT = logic_mode & ctrl[CTRL_PD_LSB +: 4];
  // dual inputs fixed to the lowest range
  assign RANGE_OUT = {8'h00, regs_ff[ADDR_RANGE[5:2]][7:0]};
  // secondary detectors take the primary range
  assign SEC_RANGE_OUT = regs_ff[ADDR_RANGE[5:2]][7:0];
  assign HYST_OUT = hyst_ff;

  // ***********************************************************
  // 100 khz clock
  // ***********************************************************
  // divider toggles every half period
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      osc_cnt_ff <= '0;
      osc_ff <= 1'h0;
    end else if (osc_cnt_ff == OSC_W'(OSC_HALF_CYC - 1)) begin
      osc_cnt_ff <= '0;
      osc_ff <= ~osc_ff;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 1'b1;
    end
  end

  // ***********************************************************
  // driver output source and mode
  // ***********************************************************
  for (genvar j = 0; j < 8; j++) begin : g_pdo
    logic [7:0] cfg;
    src_t src;
    drv_t mode;
    logic nxt_data;
    drv_t nxt_mode;
    assign cfg = (j < 4) ? regs_ff[ADDR_PDO_LO[5:2]][8*j +: 8] :
                           regs_ff[ADDR_PDO_HI[5:2]][8*(j-4) +: 8];
    assign src = src_t'(cfg[PDO_SRC_LSB +: 2]);
    assign mode = drv_t'(cfg[PDO_MODE_LSB +: 3]);

    always_comb begin
      case (src)
        SRC_ENGINE: nxt_data = SE_DATA_IN[j]; // engine level
        SRC_SMBUS: nxt_data = smb[j];         // host level
        SRC_CLOCK: nxt_data = osc_ff;
        default: nxt_data = 1'b0;
      endcase
      // charge pump refused above output 6
      if (mode == DRV_CHARGE_PUMP && j >= CP_OUTPUTS) begin
        nxt_mode = DRV_WEAK_PD;
      end else begin
        nxt_mode = mode;
      end
      // hold weakly low until supply is good
      if (!sup_s_ff) begin
        nxt_data = 1'b0;
        nxt_mode = DRV_WEAK_PD;
      end
    end

    // cleared registers give weak pull-down, low data
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        pdo_data_ff[j] <= 1'h0;
        pdo_mode_ff[3*j +: 3] <= DRV_WEAK_PD;
      end else begin
        pdo_data_ff[j] <= nxt_data;
        pdo_mode_ff[3*j +: 3] <= nxt_mode;
      end
    end
  end

  assign PDO_DATA_OUT = pdo_data_ff;
  assign PDO_MODE_OUT = pdo_mode_ff;

  // ***********************************************************
  // axi4-lite slave
  // ***********************************************************
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff, wbyte;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_wr, wr_ok, rd_ok;

  assign status = {15'h0000, sup_s_ff, filt_ff[7:4], warn,
                   SE_FAULT_OUT};
  assign AXI_AWREADY_OUT = ~aw_hold_ff & ~bvalid_ff;
  assign AXI_WREADY_OUT = ~w_hold_ff & ~bvalid_ff;
  assign AXI_ARREADY_OUT = ~rvalid_ff;
  assign do_wr = aw_hold_ff & w_hold_ff;
  assign wr_ok = wmask(awaddr_ff) != 32'h0000_0000;
  assign rd_ok = (wmask(AXI_ARADDR_IN) != 32'h0000_0000) ||
                 (AXI_ARADDR_IN == ADDR_STAT);
  assign wbyte = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                  {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      aw_hold_ff <= 1'h0;
      w_hold_ff <= 1'h0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'h0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_hold_ff <= 1'h1;
        awaddr_ff <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_hold_ff <= 1'h1;
        wdata_ff <= AXI_WDATA_IN;
        wstrb_ff <= AXI_WSTRB_IN;
      end
      if (do_wr) begin
        aw_hold_ff <= 1'h0;
        w_hold_ff <= 1'h0;
        bvalid_ff <= 1'h1;
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && AXI_BREADY_IN) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // reserved bits are masked so they always read zero
  for (genvar r = 0; r < NUM_WORDS; r++) begin : g_reg
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        regs_ff[r] <= REG_RST;
      end else if (do_wr && wr_ok && awaddr_ff[5:2] == 4'(r)) begin
        regs_ff[r] <= (regs_ff[r] & ~(wbyte & wmask(awaddr_ff))) |
                      (wdata_ff & wbyte & wmask(awaddr_ff));
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      rvalid_ff <= 1'h1;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (AXI_ARADDR_IN == ADDR_STAT) begin
        rdata_ff <= status;
      end else if (rd_ok) begin
        rdata_ff <= regs_ff[AXI_ARADDR_IN[5:2]];
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end else if (rvalid_ff && AXI_RREADY_IN) begin
      rvalid_ff <= 1'h0;
    end
  end

  assign AXI_BVALID_OUT = bvalid_ff;
  assign AXI_BRESP_OUT = bresp_ff;
  assign AXI_RVALID_OUT = rvalid_ff;
  assign AXI_RDATA_OUT = rdata_ff;
  assign AXI_RRESP_OUT = rresp_ff;

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  AST_GF_ONLY_AT_TIMEOUT: assert property (
    $changed(filt_ff[0]) |-> $past(cnt_ff[0]) >= $past(tout[0]))
    else $error("filter moved before timeout");
  AST_GF_FOLLOWS_INPUT: assert property (
    $changed(filt_ff[4]) |-> filt_ff[4] == $past(in_sel[4]))
    else $error("filter took a level not on its input");
  AST_GF_PASSES_LONG: assert property (
    (in_sel[0] != filt_ff[0] && cnt_ff[0] >= tout[0])
      |=> filt_ff[0] == $past(in_sel[0]))
    else $error("long pulse not passed");
  AST_HYST_ONLY_FAULT: assert property (
    !comp_s[0] |=> HYST_OUT[4:0] == 5'h00)
    else $error("hysteresis while in tolerance");
  AST_WARN_OR: assert property (
    SE_WARN_OUT == |(logic_mode & warn_s_ff))
    else $error("warning or wrong");
  AST_EDGE_PULSE: assert property (
    (ev[4] && logic_mode[0] && edge_mode[0]) |=> SE_LOGIC_OUT[0])
    else $error("edge gave no pulse");
  AST_LEVEL_PASS: assert property (
    (logic_mode[0] && !edge_mode[0]) |-> SE_LOGIC_OUT[0] == filt_ff[4])
    else $error("level mode not buffered");
  AST_NO_PUMP_HIGH: assert property (
    PDO_MODE_OUT[20:18] != DRV_CHARGE_PUMP &&
    PDO_MODE_OUT[23:21] != DRV_CHARGE_PUMP)
    else $error("charge pump on output 7 or 8");
  AST_SMB_DRIVE: assert property (
    (sup_s_ff && src_t'(regs_ff[ADDR_PDO_LO[5:2]][1:0]) == SRC_SMBUS)
      |=> PDO_DATA_OUT[0] == $past(smb[0]))
    else $error("bus output not following host");
  AST_SUPPLY_LOW: assert property (
    !sup_s_ff |=> PDO_DATA_OUT == 8'h00 && PDO_MODE_OUT == 24'h00_0000)
    else $error("output active before supply good");
  AST_OSC_HALF: assert property (
    $changed(osc_ff) |=> !$changed(osc_ff) [*8])
    else $error("clock half period too short");
  AST_BVALID_HOLD: assert property (
    bvalid_ff && !AXI_BREADY_IN |=> bvalid_ff)
    else $error("write response dropped");

  COV_EDGE: cover property (ev[4] && edge_mode[0] ##1 SE_LOGIC_OUT[0]);
  COV_WARN: cover property (SE_WARN_OUT);
  COV_CLK_OUT: cover property (sup_s_ff && $rose(PDO_DATA_OUT[0]));
  COV_WRITE: cover property (do_wr && wr_ok);

endmodule

// file: sim/rail_model.sv
// behavioural rails, logic pins and engine outputs seen by the block
module rail_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // requests from the bench
  input wire logic [7:0] comp_req_in,
  input wire logic [3:0] warn_req_in,
  input wire logic [3:0] pin_req_in,
  input wire logic [3:0] float_in,
  input wire logic sup_req_in,
  input wire logic [7:0] se_req_in,
  // pull-down enables from the block
  input wire logic [3:0] pd_en_in,
  // toward the block
  output logic [7:0] comp_out,
  output logic [3:0] warn_out,
  output logic [3:0] pin_out,
  output logic sup_out,
  output logic [7:0] se_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wig_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comp_out <= 8'h00;
      warn_out <= 4'h0;
      pin_out <= 4'h0;
      sup_out <= 1'b0;
      se_out <= 8'h00;
      wig_ff <= 4'h0;
    end else begin
      comp_out <= comp_req_in;
      warn_out <= warn_req_in;
      se_out <= se_req_in;
      wig_ff <= ~wig_ff;
      sup_out <= sup_req_in;
      // floating pin low only with pull-down
      pin_out <= (pin_req_in & ~float_in) | (float_in & ~pd_en_in & wig_ff);
    end
  end
endmodule

// file: sim/input_filter_output_source_bench.sv
// self-checking bench for the input filter and output source block
module input_filter_output_source_bench
  import ifos_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int US = 2;
  localparam int LIMIT = 20000;
  logic clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, sup_q, sup, se_warn;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [7:0] aw_a, ar_a, comp_q, se_q, comp, se_d, fault, programmable_driver_output, sec_rng;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic [3:0] warn_q, pin_q, flt_q, warn, pin, lgc, pd_en;
  logic [39:0] hyst;
  logic [15:0] rng;
  logic [23:0] mode;
  int error_cnt, n_checks, cyc;

  // ***********************************************************
  // instances
  // ***********************************************************
  input_filter_output_source #(.US_CYC(US)) input_filter_output_source_inst (
    .REF_CLK_IN(clk), .RESETN_IN(rst_n),
    .AXI_AWVALID_IN(aw_v), .AXI_AWREADY_OUT(aw_rdy), .AXI_AWADDR_IN(aw_a),
    .AXI_WVALID_IN(w_v), .AXI_WREADY_OUT(w_rdy), .AXI_WDATA_IN(w_d),
    .AXI_WSTRB_IN(4'hF), .AXI_BVALID_OUT(b_v), .AXI_BREADY_IN(b_r),
    .AXI_BRESP_OUT(b_resp), .AXI_ARVALID_IN(ar_v), .AXI_ARREADY_OUT(ar_rdy),
    .AXI_ARADDR_IN(ar_a), .AXI_RVALID_OUT(r_v), .AXI_RREADY_IN(r_r),
    .AXI_RDATA_OUT(r_d), .AXI_RRESP_OUT(r_resp), .COMP_IN(comp),
    .WARN_COMP_IN(warn), .DFI_PIN_IN(pin), .SUPPLY_OK_IN(sup),
    .SE_FAULT_OUT(fault), .SE_LOGIC_OUT(lgc), .SE_WARN_OUT(se_warn),
    .SE_DATA_IN(se_d), .HYST_OUT(hyst), .RANGE_OUT(rng),
    .SEC_RANGE_OUT(sec_rng), .PULLDN_EN_OUT(pd_en), .PDO_DATA_OUT(programmable_driver_output),
    .PDO_MODE_OUT(mode));
  rail_model rail_model_inst (
    .clk_in(clk), .rst_n_in(rst_n), .comp_req_in(comp_q),
    .warn_req_in(warn_q), .pin_req_in(pin_q), .float_in(flt_q),
    .sup_req_in(sup_q), .se_req_in(se_q), .pd_en_in(pd_en),
    .comp_out(comp), .warn_out(warn), .pin_out(pin), .sup_out(sup),
    .se_out(se_d));

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp)
      error_cnt++;
    if (got !== exp)
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ah, dh, oa, od, bv;
    @(posedge clk);
    aw_v <= 1'b1;
    w_v <= 1'b1;
    aw_a <= a;
    w_d <= d;
    b_r <= 1'b1;
    ah = 1'b1;
    dh = 1'b1;
    forever begin
      @(negedge clk);
      oa = ah && aw_rdy;
      od = dh && w_rdy;
      bv = b_v;
      r = b_resp;
      @(posedge clk);
      if (oa) begin
        aw_v <= 1'b0;
        ah = 1'b0;
      end
      if (od) begin
        w_v <= 1'b0;
        dh = 1'b0;
      end
      if (bv) begin
        b_r <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ah, ok, rv;
    @(posedge clk);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    ah = 1'b1;
    forever begin
      @(negedge clk);
      ok = ah && ar_rdy;
      rv = r_v;
      d = r_d;
      r = r_resp;
      @(posedge clk);
      if (ok) begin
        ar_v <= 1'b0;
        ah = 1'b0;
      end
      if (rv) begin
        r_r <= 1'b0;
        break;
      end
    end
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_CTRL, d, r);
    chk(d, REG_RST, "ctrl reset");
    rd(ADDR_PDO_LO, d, r);
    chk(d, REG_RST, "cfg reset");
    chk({programmable_driver_output, mode}, 32'h0, "outputs weak low");
    rd(8'h0C, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR}, "unmapped read");
    wr(ADDR_STAT, 32'hFFFF_FFFF, r);
    chk(r, RESP_SLVERR, "status write");
    $display("test reset done");
  endtask

  task automatic t_supply();
    logic [1:0] r;
    wr(ADDR_SMB, 32'h0000_00FF, r);
    wr(ADDR_PDO_LO, 32'h0101_0101, r);
    tick(6);
    chk(programmable_driver_output, 8'h00, "held before supply");
    sup_q <= 1'b1;
    tick(8);
    chk(programmable_driver_output[3:0], 4'hF, "bus levels");
    wr(ADDR_SMB, 32'h0000_00FA, r);
    tick(3);
    chk(programmable_driver_output[3:0], 4'hA, "bus follows");
    $display("test supply done");
  endtask

  task automatic t_filter();
    logic [1:0] r;
    logic seen;
    int n;
    wr(ADDR_GF_LO, 32'h0000_0001, r);
    wr(ADDR_HY_LO, 32'h0000_001F, r);
    comp_q <= 8'h01;
    tick(1);
    comp_q <= 8'h00;
    seen = 1'b0;
    repeat (12) begin
      @(negedge clk);
      seen |= fault[0];
    end
    chk(seen, 1'b0, "short pulse");
    @(posedge clk);
    comp_q <= 8'h01;
    @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (fault[0] !== 1'b1 && n < 50);
    chk(n, US + 3, "filter lag");
    chk(hyst[4:0], 5'h1F, "hysteresis on fault");
    @(posedge clk);
    comp_q <= 8'h00;
    tick(10);
    chk({fault[0], hyst[4:0]}, 6'h00, "fault cleared");
    $display("test filter done");
  endtask

  task automatic t_logic();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(ADDR_CTRL, 32'h0000_0001, r);
    pin_q <= 4'h1;
    comp_q <= 8'h10;
    warn_q <= 4'h1;
    tick(8);
    chk(lgc[0], 1'b1, "level copy");
    chk(fault[4], 1'b0, "analog off");
    chk(se_warn, 1'b1, "warning ored");
    rd(ADDR_STAT, d, r);
    chk({d[12], d[8]}, 2'b11, "status bits");
    wr(ADDR_CTRL, 32'h0000_0101, r);
    flt_q <= 4'h1;
    tick(8);
    chk({pd_en[0], lgc[0]}, 2'b10, "pull-down");
    flt_q <= 4'h0;
    pin_q <= 4'h0;
    wr(ADDR_PW, 32'h0000_0002, r);
    wr(ADDR_CTRL, 32'h0000_0011, r);
    tick(8);
    pin_q <= 4'h1;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      n += int'(lgc[0] === 1'b1);
    end
    chk(n, 2 * US, "pulse width");
    wr(ADDR_CTRL, 32'h0000_0000, r);
    tick(6);
    chk({se_warn, lgc[0]}, 2'b00, "analog no warn");
    $display("test logic done");
  endtask

  task automatic t_out();
    logic [1:0] r;
    int n;
    wr(ADDR_PDO_LO, 32'h0300_021D, r);
    wr(ADDR_PDO_HI, 32'h001C_0000, r);
    wr(ADDR_SMB, 32'h0000_0001, r);
    wr(ADDR_RANGE, 32'hFFFF_FFFF, r);
    se_q <= 8'h0C;
    tick(4);
    chk({programmable_driver_output[3], programmable_driver_output[2], programmable_driver_output[0]}, 3'b011, "engine, bus, off");
    chk(rng, 16'h00FF, "dual inputs one range");
    chk(sec_rng, 8'hFF, "warning range");
    chk(mode[2:0], 3'h7, "pump allowed");
    chk(mode[20:18], 3'h0, "pump refused");
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (programmable_driver_output[1] !== i[0] && n < 3000) begin
        @(negedge clk);
        n++;
      end
    end
    n = 0;
    while (programmable_driver_output[1] === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(n, OSC_HALF_CYC, "clock half period");
    $display("test outputs done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ***********************************************************
  // run
  // ***********************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {rst_n, aw_v, w_v, b_r, ar_v, r_r, sup_q} = 7'h00;
    {aw_a, ar_a, comp_q, se_q, w_d} = 64'h0;
    {warn_q, pin_q, flt_q} = 12'h000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_supply();
    t_filter();
    t_logic();
    t_out();
    stop_test();
  end
endmodule
